// ---- rtl/pdr_regs_top.sv ----
// Discharge, power-good delay, force-shutdown and buck sleep registers
//
// Notes on behaviour
// - Discharge two: four two-bit read/write selectors
// - Discharge three: reserved 7:6, three selectors
// - Selector codes: none, 100, 200, 500 ohm
// - Rising rail enable clears its selector to zero
// - Delay codes map 2.5 to 100 ms
// - Delay starts when assigned rails in range
// - I2C-driven output without termination ignores delay
// - Output three: pgood, level shifter, I2C
// - Shutdown bit pulses shutdownReq and reloads the four configuration registers
// - Shutdown bit self-clears, reads zero after reset
// - Shutdown data byte with bit zero set is not acknowledged
// - Bit zero starts shutdown, upper bits zero
// - Buck one sleep enable selects sleep code
`timescale 1ns/1ps
module pdr_regs_top
    import pdr_pkg::*;
#(
    parameter int unsigned PG_DLY_CYC [8] = PDR_PG_DLY_CYC
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Register port from the I2C target front end
    input  wire logic                   regWrStb,
    input  wire logic                   regRdStb,
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    output logic [7:0]                  regRdData,
    output logic                        regAckVld,
    output logic                        regAck,
    // Start-up configuration set chosen by the sequencer
    input  wire logic [7:0]             otpDischTwo,
    input  wire logic [PDR_DISCH3_W-1:0] otpDischThree,
    input  wire logic [PDR_PGDLY_W-1:0] otpPgDelay,
    input  wire logic [7:0]             otpBuckOneSleep,
    // Rail enables: buck5,buck6,swA1,ldo2,ldo3,swB1,swB2
    input  wire logic [PDR_RAILS-1:0]   railEnable,
    // Output three sources
    input  wire logic [1:0]             outThreeMode,
    input  wire logic                   railsInRange,
    input  wire logic                   levelShiftIn,
    input  wire logic                   outThreeI2cLevel,
    input  wire logic                   outThreeDrivesVtt,
    // Buck one voltage selection
    input  wire logic [PDR_VCODE_W-1:0] buck_one_voltage_code,
    input  wire logic                   sleepPin_n,
    // Results
    output logic [1:0]                  small_ldo_two_discharge_sel,
    output logic [1:0]                  switch_a_one_discharge_sel,
    output logic [1:0]                  buck_six_discharge_sel,
    output logic [1:0]                  buck_five_discharge_sel,
    output logic [1:0]                  switch_b_two_discharge_sel,
    output logic [1:0]                  switch_b_one_discharge_sel,
    output logic [1:0]                  small_ldo_three_discharge_sel,
    output logic                        general_output_three,
    output logic                        vttEnable,
    output logic [PDR_VCODE_W-1:0]      buckOneActiveCode,
    output logic                        shutdownReq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Spread one flag per rail into a two-bit-per-rail mask
    function automatic logic [7:0] pdrSpread(input logic [3:0] b);
        pdrSpread = {{2{b[3]}}, {2{b[2]}}, {2{b[1]}}, {2{b[0]}}};
    endfunction : pdrSpread

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    pdr_state_t               state_q;        // Sequencer state
    pdr_state_t               state_d;        // Next state
    logic [7:0]               dischTwo_q;     // Discharge two
    logic [7:0]               dischTwo_d;
    logic [PDR_DISCH3_W-1:0]  dischThree_q;   // Discharge three low bits
    logic [PDR_DISCH3_W-1:0]  dischThree_d;
    logic [PDR_PGDLY_W-1:0]   pgDelay_q;      // Delay code
    logic [PDR_PGDLY_W-1:0]   pgDelay_d;
    logic [7:0]               buckSleep_q;    // Buck one sleep control
    logic [7:0]               buckSleep_d;
    logic [PDR_RAILS-1:0]     railEn_q;       // Last rail enables
    logic [7:0]               rdData_q;       // Read data
    logic [7:0]               rdData_d;
    logic                     ackVld_q;       // Answer strobe
    logic                     ack_q;          // Acknowledge flag
    logic                     ack_d;
    logic                     outThree_q;     // Pin value
    logic                     outThree_d;
    logic                     vtt_q;          // Termination enable
    logic [PDR_VCODE_W-1:0]   code_q;         // Active buck one code
    logic [PDR_VCODE_W-1:0]   code_d;
    logic                     shdn_q;         // Shutdown pulse

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire hitTwo   = (regAddr == PDR_ADDR_DISCH_TWO);
    wire hitThree = (regAddr == PDR_ADDR_DISCH_THREE);
    wire hitDelay = (regAddr == PDR_ADDR_PG_DELAY);
    wire hitShdn  = (regAddr == PDR_ADDR_FORCE_SHDN);
    wire hitSleep = (regAddr == PDR_ADDR_BUCK1_SLEEP);
    wire hitAny   = hitTwo | hitThree | hitDelay | hitShdn | hitSleep;
    wire running  = (state_q == PDR_ST_RUN);
    wire wrOk     = regWrStb & running;
    wire shdnHit  = wrOk & hitShdn & regWrData[PDR_SHDN_BIT];
    // Rising rail enables; an enable edge beats a same-cycle write
    wire [PDR_RAILS-1:0] railRise = railEnable & ~railEn_q;
    wire [7:0] clrTwo   = pdrSpread(railRise[3:0]);
    wire [7:0] clrThree = pdrSpread({1'b0, railRise[6:4]});

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Shutdown goes back through load, which reloads the configuration registers
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            PDR_ST_LOAD: state_d = PDR_ST_RUN;
            PDR_ST_RUN:  state_d = shdnHit ? PDR_ST_SHDN : PDR_ST_RUN;
            PDR_ST_SHDN: state_d = PDR_ST_LOAD;
            default:     state_d = PDR_ST_LOAD; // Code 2'h2 is illegal
        endcase
    end

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    // Defaults from start-up set
    always_comb
    begin
        dischTwo_d   = dischTwo_q;
        dischThree_d = dischThree_q;
        pgDelay_d    = pgDelay_q;
        buckSleep_d  = buckSleep_q;
        if (state_q != PDR_ST_RUN)
        begin
            // Load, and reload after shutdown, from the configuration
            dischTwo_d   = otpDischTwo;
            dischThree_d = otpDischThree;
            pgDelay_d    = otpPgDelay;
            buckSleep_d  = otpBuckOneSleep;
        end
        else
        begin
            if (wrOk && hitTwo)
                dischTwo_d = regWrData;
            if (wrOk && hitThree)
                dischThree_d = regWrData[PDR_DISCH3_W-1:0];
            if (wrOk && hitDelay)
                pgDelay_d = regWrData[PDR_PGDLY_W-1:0];
            if (wrOk && hitSleep)
                buckSleep_d = regWrData;
            dischTwo_d   = dischTwo_d & ~clrTwo;
            dischThree_d = dischThree_d & ~clrThree[PDR_DISCH3_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------
    // Shutdown bit always reads zero
    always_comb
    begin
        rdData_d = PDR_BYTE_ZERO;
        if (hitTwo)
            rdData_d = dischTwo_q;
        else if (hitThree)
            rdData_d = {2'h0, dischThree_q};
        else if (hitDelay)
            rdData_d = {5'h00, pgDelay_q};
        else if (hitSleep)
            rdData_d = buckSleep_q;
    end

    assign ack_d = hitAny & running & ~shdnHit;

    // ------------------------------------------------------------
    // Output three and buck one code
    // ------------------------------------------------------------
    wire modeI2c = (outThreeMode == PDR_OUT_I2C);
    wire modeLvl = (outThreeMode == PDR_OUT_LVL);
    wire pgDone;   // Delay expired
    wire timerIn = modeI2c ? outThreeI2cLevel :
                   modeLvl ? levelShiftIn : railsInRange;
    assign outThree_d = modeI2c ? outThreeI2cLevel : pgDone;

    assign code_d = (buckSleep_q[PDR_SLP_EN_BIT] && !sleepPin_n) ?
        buckSleep_q[PDR_SLP_VID_LSB +: PDR_VCODE_W] : buck_one_voltage_code;

    pdr_pg_timer #(
        .DLY_CYC  (PG_DLY_CYC)
    ) pdr_pg_timer_i (
        .clk      (clk),
        .rst_n    (rst_n),
        .startLvl (timerIn & running),
        .dlyCode  (pgDelay_q),
        .doneLvl  (pgDone)
    );

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    // Configuration registers; reset to zero until the set is loaded
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= PDR_ST_LOAD;
            dischTwo_q   <= PDR_BYTE_ZERO;
            dischThree_q <= '0;
            pgDelay_q    <= '0;
            buckSleep_q  <= PDR_BYTE_ZERO;
            railEn_q     <= '0;
        end
        else
        begin
            state_q      <= state_d;
            dischTwo_q   <= dischTwo_d;
            dischThree_q <= dischThree_d;
            pgDelay_q    <= pgDelay_d;
            buckSleep_q  <= buckSleep_d;
            railEn_q     <= railEnable;
        end
    end

    // Bus answers and pin outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData_q   <= PDR_BYTE_ZERO;
            ackVld_q   <= 1'b0;
            ack_q      <= 1'b0;
            outThree_q <= 1'b0;
            vtt_q      <= 1'b0;
            code_q     <= '0;
            shdn_q     <= 1'b0;
        end
        else
        begin
            if (regRdStb)
                rdData_q <= rdData_d;
            ackVld_q   <= regWrStb | regRdStb;
            ack_q      <= ack_d;
            outThree_q <= outThree_d & running;
            // Termination follows the delayed level when tied to it
            vtt_q      <= outThreeDrivesVtt & pgDone & running;
            code_q     <= code_d;
            shdn_q     <= shdnHit;
        end
    end

    // ------------------------------------------------------------
    // Output wiring, all from flip-flops
    // ------------------------------------------------------------
    assign regRdData                     = rdData_q;
    assign regAckVld                     = ackVld_q;
    assign regAck                        = ack_q;
    assign small_ldo_two_discharge_sel   = dischTwo_q[7:6];
    assign switch_a_one_discharge_sel    = dischTwo_q[5:4];
    assign buck_six_discharge_sel        = dischTwo_q[3:2];
    assign buck_five_discharge_sel       = dischTwo_q[1:0];
    assign switch_b_two_discharge_sel    = dischThree_q[5:4];
    assign switch_b_one_discharge_sel    = dischThree_q[3:2];
    assign small_ldo_three_discharge_sel = dischThree_q[1:0];
    assign general_output_three          = outThree_q;
    assign vttEnable                     = vtt_q;
    assign buckOneActiveCode             = code_q;
    assign shutdownReq                   = shdn_q;

endmodule : pdr_regs_top

// ---- rtl/pdr_pkg.sv ----
// Package: register map, field layout, modes and timing of the block
package pdr_pkg;

    // ------------------------------------------------------------
    // Register offsets on the internal register port
    // ------------------------------------------------------------
    localparam logic [7:0] PDR_ADDR_DISCH_TWO   = 8'h41; // Discharge two
    localparam logic [7:0] PDR_ADDR_DISCH_THREE = 8'h42; // Discharge three
    localparam logic [7:0] PDR_ADDR_PG_DELAY    = 8'h43; // Pgood delay one
    localparam logic [7:0] PDR_ADDR_FORCE_SHDN  = 8'h91; // Force shutdown
    localparam logic [7:0] PDR_ADDR_BUCK1_SLEEP = 8'h92; // Buck one sleep

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int PDR_SEL_W        = 2;  // Discharge selector width
    localparam int PDR_DISCH3_W     = 6;  // Writable bits of disch three
    localparam int PDR_PGDLY_W      = 3;  // Delay code width
    localparam int PDR_VCODE_W      = 7;  // Voltage code width
    localparam int PDR_SHDN_BIT     = 0;  // Force-shutdown bit position
    localparam int PDR_SLP_EN_BIT   = 0;  // Sleep enable position
    localparam int PDR_SLP_VID_LSB  = 1;  // Sleep code low bit
    localparam int PDR_RAILS        = 7;  // Rails with a selector
    localparam logic [7:0] PDR_BYTE_ZERO = 8'h00; // Reset / reserved value
    localparam logic [1:0] PDR_SEL_NONE  = 2'h0;  // No discharge

    // Selector encodings
    localparam logic [1:0] PDR_SEL_100R = 2'h1; // 100 ohm path
    localparam logic [1:0] PDR_SEL_200R = 2'h2; // 200 ohm path
    localparam logic [1:0] PDR_SEL_500R = 2'h3; // 500 ohm path

    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PDR_OUT_PGOOD = 2'h0, // System power good
        PDR_OUT_LVL   = 2'h1, // Level shifter
        PDR_OUT_I2C   = 2'h2  // Driven by register over I2C
    } pdr_out_mode_t;

    typedef enum logic [1:0] {
        PDR_ST_LOAD = 2'h0, // Load start-up defaults
        PDR_ST_RUN  = 2'h1, // Normal operation
        PDR_ST_SHDN = 2'h3  // Emergency shutdown pulse
    } pdr_state_t;

    // ------------------------------------------------------------
    // Timing: delays in microseconds, clock in MHz
    // ------------------------------------------------------------
    localparam int unsigned PDR_CLK_MHZ = 200;
    localparam int unsigned PDR_PG_DLY_US [8] =
        '{2500, 5000, 10000, 15000, 20000, 50000, 75000, 100000};
    localparam int PDR_CNT_W = 25; // Holds 100 ms at 200 MHz

    // Cycles for a least delay (exact multiple, so no rounding lost)
    function automatic int unsigned pdrUsToCyc(input int unsigned us);
        pdrUsToCyc = us * PDR_CLK_MHZ;
    endfunction : pdrUsToCyc

    localparam int unsigned PDR_PG_DLY_CYC [8] = '{
        pdrUsToCyc(PDR_PG_DLY_US[0]), pdrUsToCyc(PDR_PG_DLY_US[1]),
        pdrUsToCyc(PDR_PG_DLY_US[2]), pdrUsToCyc(PDR_PG_DLY_US[3]),
        pdrUsToCyc(PDR_PG_DLY_US[4]), pdrUsToCyc(PDR_PG_DLY_US[5]),
        pdrUsToCyc(PDR_PG_DLY_US[6]), pdrUsToCyc(PDR_PG_DLY_US[7])};

endpackage : pdr_pkg

// ---- rtl/pdr_pg_timer.sv ----
// Power-good delay timer: qualifies a level for a code-selected time
`timescale 1ns/1ps
module pdr_pg_timer
    import pdr_pkg::*;
#(
    parameter int unsigned DLY_CYC [8] = PDR_PG_DLY_CYC
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   startLvl,
    input  wire logic [PDR_PGDLY_W-1:0] dlyCode,
    output logic                        doneLvl
);

    // ------------------------------------------------------------
    // Counter and target
    // ------------------------------------------------------------
    logic [PDR_CNT_W-1:0] cnt_q;     // Cycles since level went high
    logic [PDR_CNT_W-1:0] cnt_d;     // Next count
    logic                 done_q;    // Delay expired
    logic                 done_d;    // Next expired state
    logic [PDR_CNT_W-1:0] target;    // Selected delay in cycles
    logic                 reached;   // Count hit target

    // Table lookup; code changes mid-count take the new target at once
    assign target  = DLY_CYC[dlyCode][PDR_CNT_W-1:0];
    assign reached = (cnt_q >= target - 1'b1);

    assign cnt_d  = !startLvl ? '0 :
                    reached   ? cnt_q : cnt_q + 1'b1;
    // A drop of the level clears power good at once, no delay
    assign done_d = startLvl & (done_q | reached);

    // Count register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign doneLvl = done_q;

endmodule : pdr_pg_timer

// ---- dv/pdr_regs_monitor.sv ----
// Checker: register port answers and output timing of the block
`timescale 1ns/1ps
module pdr_regs_monitor
    import pdr_pkg::*;
#(
    parameter int unsigned PG_DLY_CYC [8] = PDR_PG_DLY_CYC
)
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       regAckVld,
    input wire logic       regAck,
    input wire logic [6:0] railEnable,
    input wire logic [1:0] outThreeMode,
    input wire logic       railsInRange,
    input wire logic       general_output_three,
    input wire logic [1:0] buck_five_discharge_sel,
    input wire logic [1:0] small_ldo_three_discharge_sel,
    input wire logic       shutdownReq
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Any offset outside the five mapped ones
    logic unmappedAddr;
    assign unmappedAddr = !(regAddr inside {PDR_ADDR_DISCH_TWO,
        PDR_ADDR_DISCH_THREE, PDR_ADDR_PG_DELAY, PDR_ADDR_FORCE_SHDN,
        PDR_ADDR_BUCK1_SLEEP});

    // Shutdown request and its silent answer
    sequence s_shdnWr;
        regWrStb && regAddr == PDR_ADDR_FORCE_SHDN && regWrData[0];
    endsequence
    sequence s_shdnAns;
        regAckVld && !regAck && shutdownReq;
    endsequence

    property p_ack;
        1'b1 |=> regAckVld == $past(regWrStb || regRdStb);
    endproperty
    property p_shdn;
        s_shdnWr |=> s_shdnAns;
    endproperty
    property p_shdnPulse;
        shutdownReq |=> !shutdownReq [*2];
    endproperty
    property p_unmapped;
        regWrStb && unmappedAddr |=> regAckVld && !regAck;
    endproperty
    property p_shdnRd;
        regRdStb && regAddr == PDR_ADDR_FORCE_SHDN |=> regRdData == 8'h00;
    endproperty
    property p_rsvdThree;
        regRdStb && regAddr == PDR_ADDR_DISCH_THREE |=> !regRdData[7:6];
    endproperty
    property p_rsvdDelay;
        regRdStb && regAddr == PDR_ADDR_PG_DELAY |=> !regRdData[7:3];
    endproperty
    property p_clearFive;
        $rose(railEnable[0]) |=> buck_five_discharge_sel == PDR_SEL_NONE;
    endproperty
    property p_clearLdo;
        $rose(railEnable[4]) |=> small_ldo_three_discharge_sel == 2'h0;
    endproperty
    property p_pgLow;
        $fell(railsInRange) && outThreeMode == PDR_OUT_PGOOD
            |-> ##2 !general_output_three;
    endproperty

    a_ack: assert property (p_ack)
        else $error("answer strobe not one cycle after request");
    a_shdn: assert property (p_shdn)
        else $error("shutdown byte acknowledged or no shutdown");
    a_shdnPulse: assert property (p_shdnPulse)
        else $error("shutdown request does not clear itself");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped write acknowledged");
    a_shdnRd: assert property (p_shdnRd)
        else $error("shutdown register reads nonzero");
    a_rsvdThree: assert property (p_rsvdThree)
        else $error("discharge three reserved bits nonzero");
    a_rsvdDelay: assert property (p_rsvdDelay)
        else $error("delay register reserved bits nonzero");
    a_clearFive: assert property (p_clearFive)
        else $error("buck five selector not cleared on enable");
    a_clearLdo: assert property (p_clearLdo)
        else $error("ldo three selector not cleared on enable");
    a_pgLow: assert property (p_pgLow)
        else $error("output three not low two cycles after drop");
endmodule : pdr_regs_monitor

bind pdr_regs_top pdr_regs_monitor #(.PG_DLY_CYC(PG_DLY_CYC))
    pdr_regs_monitor_i (.*);

// ---- dv/pdr_host_model.sv ----
// Host model: byte writes and reads on the block's register port
`timescale 1ns/1ps
module pdr_host_model
(
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    input  wire logic       regAckVld,
    input  wire logic       regAck,
    output logic            regWrStb,
    output logic            regRdStb,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData
);
    // Idle port at time zero
    initial
    begin
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    // One byte; strobe stands one cycle, answer taken the next edge
    task automatic xfer(input logic wr, input logic [7:0] addr,
        input logic [7:0] data, output logic [7:0] rd, output logic ack);
        @(posedge clk);
        #1;
        regWrStb = wr;
        regRdStb = !wr;
        regAddr = addr;
        regWrData = data;
        @(posedge clk);
        #1;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        // Released lines flip so a stale value never matches
        regAddr = ~addr;
        regWrData = ~data;
        rd = regRdData;
        ack = regAckVld ? regAck : 1'bx;
    endtask : xfer
endmodule : pdr_host_model

// ---- dv/pdr_regs_top_tb.sv ----
// Testbench: register block exercised through the host model
`timescale 1ns/1ps
module pdr_regs_top_tb
    import pdr_pkg::*;
;
    // Shortened delays keep the run brief
    localparam int unsigned DLY [8] = '{5, 10, 20, 30, 40, 100, 150, 200};
    logic clk, rst_n, regWrStb, regRdStb, regAckVld, regAck;
    logic [7:0] regAddr, regWrData, regRdData, otpDischTwo, otpBuckOneSleep;
    logic [5:0] otpDischThree;
    logic [2:0] otpPgDelay;
    logic [6:0] railEnable, buck_one_voltage_code, buckOneActiveCode;
    logic [1:0] outThreeMode, buck_five_discharge_sel, sel;
    logic railsInRange, levelShiftIn, outThreeI2cLevel, outThreeDrivesVtt;
    logic sleepPin_n, general_output_three, shutdownReq, vttEnable;
    logic [1:0] sl2, sa1, sb6, sw2, sw1, sl3; // Selector pins
    int errors, samples_checked;

    pdr_regs_top #(.PG_DLY_CYC(DLY)) pdr_regs_top_i (.*,
        .small_ldo_two_discharge_sel(sl2), .switch_a_one_discharge_sel(sa1),
        .buck_six_discharge_sel(sb6), .switch_b_two_discharge_sel(sw2),
        .switch_b_one_discharge_sel(sw1),
        .small_ldo_three_discharge_sel(sl3));
    pdr_host_model pdr_host_model_i (.*);

    // --------------------------------------------------
    // Compare, access and timing helpers
    // --------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic ea);
        logic [7:0] r;
        logic k;
        pdr_host_model_i.xfer(1'b1, a, d, r, k);
        chk("write ack", {7'h0, ea}, {7'h0, k});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic ea);
        logic [7:0] r;
        logic k;
        pdr_host_model_i.xfer(1'b0, a, 8'h00, r, k);
        chk("read ack", {7'h0, ea}, {7'h0, k});
        chk($sformatf("read %h", a), e, r);
    endtask : rd

    task automatic code(input logic [6:0] e);
        repeat (2) @(posedge clk);
        #1;
        chk("buck code", {1'b0, e}, {1'b0, buckOneActiveCode});
    endtask : code

    // Edges until pin high, allowed one to three past the delay
    task automatic pgRun(input int unsigned d);
        int unsigned n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (general_output_three !== 1'b1 && n < 400);
        chk("pin delay ok", 8'h01, {7'h0, n >= d + 1 && n <= d + 3});
    endtask : pgRun

    task automatic final_report;
        $display("Checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard well past the expected run
    initial
    begin
        #40us;
        errors++;
        $display("[FAIL] watchdog expected end seen hang");
        final_report;
    end

    // --------------------------------------------------
    // Main sequence
    // --------------------------------------------------
    initial
    begin
        {errors, samples_checked} = '0;
        rst_n = 1'b0;
        {otpDischTwo, otpDischThree, otpPgDelay} = {8'h3c, 6'h2d, 3'h5};
        otpBuckOneSleep = 8'ha7;
        {railEnable, outThreeMode, railsInRange, levelShiftIn} = '0;
        {outThreeI2cLevel, outThreeDrivesVtt, sleepPin_n} = 3'h3;
        buck_one_voltage_code = 7'h22;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        rd(PDR_ADDR_DISCH_TWO, 8'h3c, 1'b1);
        rd(PDR_ADDR_DISCH_THREE, 8'h2d, 1'b1);
        rd(PDR_ADDR_PG_DELAY, 8'h05, 1'b1);
        rd(PDR_ADDR_FORCE_SHDN, 8'h00, 1'b1);
        rd(PDR_ADDR_BUCK1_SLEEP, 8'ha7, 1'b1);
        // Every selector code in every field
        for (int c = 0; c < 4; c++)
        begin
            sel = c[1:0];
            wr(PDR_ADDR_DISCH_TWO, {4{sel}}, 1'b1);
            rd(PDR_ADDR_DISCH_TWO, {4{sel}}, 1'b1);
            chk("buck five sel", {6'h0, sel}, {6'h0, buck_five_discharge_sel});
            chk("pins two", {4{sel}},
                {sl2, sa1, sb6, buck_five_discharge_sel});
            wr(PDR_ADDR_DISCH_THREE, {4{sel}}, 1'b1);
            rd(PDR_ADDR_DISCH_THREE, {2'h0, {3{sel}}}, 1'b1);
            chk("pins three", {2'h0, {3{sel}}},
                {2'h0, sw2, sw1, sl3});
        end
        wr(PDR_ADDR_PG_DELAY, 8'hff, 1'b1);
        rd(PDR_ADDR_PG_DELAY, 8'h07, 1'b1);
        wr(PDR_ADDR_FORCE_SHDN, 8'hfe, 1'b1);
        rd(PDR_ADDR_FORCE_SHDN, 8'h00, 1'b1);
        wr(8'h50, 8'h5a, 1'b0);
        rd(8'h50, 8'h00, 1'b0);
        // Rail enable clears its selector
        wr(PDR_ADDR_DISCH_TWO, 8'hff, 1'b1);
        wr(PDR_ADDR_DISCH_THREE, 8'h3f, 1'b1);
        railEnable = 7'h08;
        rd(PDR_ADDR_DISCH_TWO, 8'h3f, 1'b1);
        railEnable = 7'h7f;
        rd(PDR_ADDR_DISCH_TWO, 8'h00, 1'b1);
        rd(PDR_ADDR_DISCH_THREE, 8'h00, 1'b1);
        railEnable = 7'h00;
        // Sleep code selection
        sleepPin_n = 1'b0;
        wr(PDR_ADDR_BUCK1_SLEEP, {7'h55, 1'b1}, 1'b1);
        code(7'h55);
        sleepPin_n = 1'b1;
        code(7'h22);
        sleepPin_n = 1'b0;
        wr(PDR_ADDR_BUCK1_SLEEP, {7'h55, 1'b0}, 1'b1);
        code(7'h22);
        // Each delay code in pgood mode
        for (int k = 0; k < 8; k++)
        begin
            wr(PDR_ADDR_PG_DELAY, k[7:0], 1'b1);
            railsInRange = 1'b1;
            pgRun(DLY[k]);
            railsInRange = 1'b0;
            repeat (2) @(posedge clk);
            #1 chk("pin low", 8'h00, {7'h0, general_output_three});
        end
        // Level shifter mode also delayed
        outThreeMode = PDR_OUT_LVL;
        wr(PDR_ADDR_PG_DELAY, 8'h00, 1'b1);
        levelShiftIn = 1'b1;
        pgRun(DLY[0]);
        chk("vtt on", 8'h01, {7'h0, vttEnable});
        levelShiftIn = 1'b0;
        // Register-driven mode ignores the delay
        outThreeMode = PDR_OUT_I2C;
        wr(PDR_ADDR_PG_DELAY, 8'h07, 1'b1);
        outThreeI2cLevel = 1'b1;
        code(buck_one_voltage_code);
        chk("i2c pin", 8'h01, {7'h0, general_output_three});
        chk("vtt wait", 8'h00, {7'h0, vttEnable});
        outThreeI2cLevel = 1'b0;
        code(buck_one_voltage_code);
        chk("i2c pin", 8'h00, {7'h0, general_output_three});
        // Emergency shutdown reloads defaults
        otpDischTwo = 8'h96;
        wr(PDR_ADDR_DISCH_TWO, 8'h5a, 1'b1);
        wr(PDR_ADDR_FORCE_SHDN, 8'h01, 1'b0);
        chk("shutdown req", 8'h01, {7'h0, shutdownReq});
        // Requests are refused until the reload cycles are over
        repeat (2) @(posedge clk);
        rd(PDR_ADDR_DISCH_TWO, 8'h96, 1'b1);
        rd(PDR_ADDR_FORCE_SHDN, 8'h00, 1'b1);
        final_report;
    end
endmodule : pdr_regs_top_tb
